// File: common/sar_pkg.sv
// package of constants for the system access router.
// assumes one clock domain and a combinational/registered decision per request.
package sar_pkg;
    // initiator codes
    typedef enum logic [1:0] {
        SAR_INIT_CPU   = 2'h0,
        SAR_INIT_DMA   = 2'h1,
        SAR_INIT_PCI   = 2'h2,
        SAR_INIT_LOCAL = 2'h3
    } sar_init_type;
    // target codes
    typedef enum logic [2:0] {
        SAR_TGT_BOOT    = 3'h0,
        SAR_TGT_SDRAM   = 3'h1,
        SAR_TGT_PCI_MEM = 3'h2,
        SAR_TGT_PCI_IO  = 3'h3,
        SAR_TGT_PCI_CFG = 3'h4,
        SAR_TGT_EXTDEV  = 3'h5,
        SAR_TGT_INTREG  = 3'h6,
        SAR_TGT_LOCAL   = 3'h7
    } sar_tgt_type;
    // path codes for a granted access
    typedef enum logic [2:0] {
        SAR_PATH_NONE   = 3'h0,
        SAR_PATH_DIRECT = 3'h1,
        SAR_PATH_DMA    = 3'h2,
        SAR_PATH_PCIWIN = 3'h3,
        SAR_PATH_SELFCFG = 3'h4
    } sar_path_type;
    // reset base of the internal register space
    localparam logic [35:0] SAR_INTREG_BASE_RST = 36'h0_1fa0_0000;
    // pci command register reset values
    localparam logic [15:0] SAR_PCI_COMMAND_REG_RST_NEG  = 16'h0000;
    localparam logic [15:0] SAR_PCI_COMMAND_REG_RST_ASRT = 16'h0006;
    // external select lines are numbered from this one
    localparam int SAR_EXT_FIRST = 2;
    localparam int SAR_EXT_NUM   = 7;
    localparam logic [2:0] SAR_EXT_IDX_W = 3'h0;
    // cpu interface limit, in mhz, and the local clock rate
    localparam int SAR_CPU_FMAX_MHZ = 100;
    localparam int SAR_CLK_MHZ      = 125;
endpackage

// File: core/sar_ext_sel.sv
// one external device-select slot: decides whether the slot is decodable
// and on which bus it sits. assumes synchronous inputs on clk.
`timescale 1ns/100ps
`default_nettype none
module sar_ext_sel
(
    input  wire logic clk,
    input  wire logic resetn,
    input  wire logic repurposed,    // line used for serial, dma handshake or gpio
    input  wire logic on_local_bus,  // placement of the device
    output logic      decodable_r,   // slot answers address decode
    output logic      mem_bus_r      // slot sits on memory bus
);
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            decodable_r <= 1'b0;
        else
            decodable_r <= !repurposed;
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            mem_bus_r <= 1'b1;
        else
            mem_bus_r <= !on_local_bus;
    end
endmodule
`default_nettype wire

// File: core/sar_cmd_reg.sv
// pci command register with strap-dependent reset value.
// the strap is caught by a clocked load after reset release, never by the async reset.
`timescale 1ns/100ps
`default_nettype none
module sar_cmd_reg
(
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        central_resource_strap, // high when asserted
    input  wire logic        wr_en,                  // config write strobe
    input  wire logic [15:0] wr_data,
    output logic      [15:0] pci_command_reg
);
    import sar_pkg::*;
    logic loaded_r; // strap value has been applied

    // first edge after release marks the strap as taken
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            loaded_r <= 1'b0;
        else
            loaded_r <= 1'b1;
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            pci_command_reg <= SAR_PCI_COMMAND_REG_RST_NEG;
        else if (!loaded_r)
            pci_command_reg <= central_resource_strap ? SAR_PCI_COMMAND_REG_RST_ASRT : SAR_PCI_COMMAND_REG_RST_NEG;
        else if (wr_en)
            pci_command_reg <= wr_data;
    end
endmodule
`default_nettype wire

// File: core/sar_router.sv
// access routing and permission decision of the system controller.
// assumes requests arrive as one-cycle strobes with initiator, target and
// extra qualifiers already decoded; answer comes one cycle later.
`timescale 1ns/100ps
`default_nettype none
// How it works
// - internal registers decode at reset base
// - pci masters never forward foreign config
// - pci masters reach own config two ways; code uses req_self_cfg only, req_idsel unused
// - local masters served through dma logic
// - local masters never routed back locally
// - local boot/ext only on memory bus
// - repurposed select lines never decode
// - pci spaces only via windows, as master
// - pci masters get rom, sdram, ext, regs
// - external devices on either bus routed
// - command register reset follows strap
// - only pipelined non-block cpu writes
// - cpu interface up to 100 mhz
module sar_router
#(
    parameter int EXT_NUM = sar_pkg::SAR_EXT_NUM
)
(
    input  wire logic                  clk,
    input  wire logic                  resetn,
    input  wire logic                  req_valid,       // one-cycle request strobe
    input  wire sar_pkg::sar_init_type req_init,        // who asks
    input  wire sar_pkg::sar_tgt_type  req_tgt,         // what is addressed
    input  wire logic [2:0]            req_ext_idx,     // select line index minus two
    input  wire logic                  req_self_cfg,    // config aimed at this device
    input  wire logic                  req_idsel,       // idsel driven by central resource
    input  wire logic                  req_cpu_write,   // cpu non-block write
    input  wire logic                  req_cpu_pipelined, // write uses pipelined mode
    input  wire logic                  win_hit,         // a pci address window matched
    input  wire logic [EXT_NUM-1:0]    ext_repurposed,  // per-line alternate function
    input  wire logic [EXT_NUM-1:0]    ext_on_local,    // per-line placement
    input  wire logic                  central_resource_strap,
    input  wire logic                  cmd_wr_en,
    input  wire logic [15:0]           cmd_wr_data,
    input  wire logic                  base_wr_en,      // relocate internal registers
    input  wire logic [35:0]           base_wr_data,
    output logic                       rsp_valid,       // answer strobe
    output logic                       rsp_grant_r,     // access forwarded
    output logic                       rsp_error_r,     // access refused with error
    output sar_pkg::sar_path_type      rsp_path_r,      // path taken
    output logic                       rsp_pci_master_r, // device acts as pci master
    output logic                       rsp_local_bus_r, // ext device on local bus
    output logic [EXT_NUM-1:0]         ext_device_select_r, // one-hot select
    output logic [35:0]                intreg_base_r,   // internal register base
    output logic [15:0]                pci_command_reg
);
    import sar_pkg::*;

    logic [EXT_NUM-1:0] ext_ok;      // slot decodable
    logic [EXT_NUM-1:0] ext_mem;     // slot on memory bus
    logic               allow;       // permission outcome
    sar_path_type       path;        // chosen path
    logic               as_master;   // pci window used
    logic               ext_sel_ok;  // addressed slot valid
    logic               ext_sel_mem; // addressed slot on memory bus
    logic               idx_ok;      // index in range
    logic               valid_r;     // response strobe

    // one slot tracker per select line
    genvar g;
    generate
        for (g = 0; g < EXT_NUM; g++)
        begin : g_ext
            sar_ext_sel u_ext
            (
                .clk          (clk),
                .resetn       (resetn),
                .repurposed   (ext_repurposed[g]),
                .on_local_bus (ext_on_local[g]),
                .decodable_r  (ext_ok[g]),
                .mem_bus_r    (ext_mem[g])
            );
        end
    endgenerate

    // command register with strap-chosen reset
    sar_cmd_reg u_cmd
    (
        .clk                    (clk),
        .resetn                 (resetn),
        .central_resource_strap (central_resource_strap),
        .wr_en                  (cmd_wr_en),
        .wr_data                (cmd_wr_data),
        .pci_command_reg        (pci_command_reg)
    );

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            intreg_base_r <= SAR_INTREG_BASE_RST;
        else if (base_wr_en)
            intreg_base_r <= base_wr_data;
    end

    // addressed select slot lookup; out-of-range index counts as absent
    always_comb
    begin
        idx_ok      = 32'(req_ext_idx) < EXT_NUM;
        ext_sel_ok  = 1'b0;
        ext_sel_mem = 1'b0;
        if (idx_ok)
        begin
            ext_sel_ok  = ext_ok[req_ext_idx];
            ext_sel_mem = ext_mem[req_ext_idx];
        end
    end

    // permission and path decision
    always_comb
    begin
        allow     = 1'b0;
        path      = SAR_PATH_NONE;
        as_master = 1'b0;
        case (req_tgt)
            SAR_TGT_BOOT, SAR_TGT_SDRAM, SAR_TGT_INTREG:
            begin
                // local boot needs memory bus
                // boot rom always sits on the memory bus here
                allow = 1'b1;
                path  = SAR_PATH_DIRECT;
            end
            SAR_TGT_PCI_MEM, SAR_TGT_PCI_CFG, SAR_TGT_PCI_IO:
            begin
                if (req_init == SAR_INIT_PCI)
                begin
                    allow = (req_tgt == SAR_TGT_PCI_CFG) && req_self_cfg;
                    path  = allow ? SAR_PATH_SELFCFG : SAR_PATH_NONE;
                    if (req_tgt == SAR_TGT_PCI_IO)
                        allow = 1'b0;
                end
                else
                begin
                    allow     = win_hit;
                    as_master = win_hit;
                    path      = win_hit ? SAR_PATH_PCIWIN : SAR_PATH_NONE;
                end
            end
            SAR_TGT_EXTDEV:
            begin
                allow = ext_sel_ok;
                if (req_init == SAR_INIT_LOCAL && !ext_sel_mem)
                    allow = 1'b0;
                path = allow ? SAR_PATH_DIRECT : SAR_PATH_NONE;
            end
            SAR_TGT_LOCAL:
            begin
                allow = req_init != SAR_INIT_LOCAL && req_init != SAR_INIT_PCI;
                path  = allow ? SAR_PATH_DIRECT : SAR_PATH_NONE;
            end
            default:
            begin
                allow = 1'b0;
                path  = SAR_PATH_NONE;
            end
        endcase
        // pci masters are also let through to local-bus targets? kept out: not listed
        // non-pipelined cpu writes refused
        if (req_init == SAR_INIT_CPU && req_cpu_write && !req_cpu_pipelined)
            allow = 1'b0;
        if (allow && req_init == SAR_INIT_LOCAL)
            path = SAR_PATH_DMA;
        if (!allow)
        begin
            path      = SAR_PATH_NONE;
            as_master = 1'b0;
        end
    end

    // answer strobe one cycle after the request
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            valid_r <= 1'b0;
        else
            valid_r <= req_valid;
    end

    assign rsp_valid = valid_r;

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rsp_grant_r      <= 1'b0;
            rsp_error_r      <= 1'b0;
            rsp_path_r       <= SAR_PATH_NONE;
            rsp_pci_master_r <= 1'b0;
            rsp_local_bus_r  <= 1'b0;
        end
        else if (req_valid)
        begin
            rsp_grant_r      <= allow;
            rsp_error_r      <= !allow;
            rsp_path_r       <= path;
            rsp_pci_master_r <= as_master;
            rsp_local_bus_r  <= allow && req_tgt == SAR_TGT_EXTDEV && !ext_sel_mem;
        end
        else
        begin
            rsp_grant_r      <= 1'b0;
            rsp_error_r      <= 1'b0;
            rsp_path_r       <= SAR_PATH_NONE;
            rsp_pci_master_r <= 1'b0;
            rsp_local_bus_r  <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            ext_device_select_r <= '0;
        else if (req_valid && allow && req_tgt == SAR_TGT_EXTDEV)
            ext_device_select_r <= EXT_NUM'(1) << req_ext_idx;
        else
            ext_device_select_r <= '0;
    end

    // logic is single-stage, so the 125 mhz clock covers the 100 mhz cpu bus
endmodule
`default_nettype wire

// File: bench/sar_router_monitor.sv
// checker for the access router, bound to every sar_router.
// sees router ports only; one clock, async active-low reset.
`timescale 1ns/100ps
`default_nettype none
module sar_router_monitor
    import sar_pkg::*;
(
    input wire logic                  clk,
    input wire logic                  resetn,
    input wire logic                  req_valid,
    input wire sar_pkg::sar_init_type req_init,
    input wire sar_pkg::sar_tgt_type  req_tgt,
    input wire logic                  req_self_cfg,
    input wire logic                  req_cpu_write,
    input wire logic                  req_cpu_pipelined,
    input wire logic                  win_hit,
    input wire logic                  central_resource_strap,
    input wire logic                  rsp_valid,
    input wire logic                  rsp_grant_r,
    input wire logic                  rsp_error_r,
    input wire sar_pkg::sar_path_type rsp_path_r,
    input wire logic                  rsp_pci_master_r,
    input wire logic [35:0]           intreg_base_r,
    input wire logic [15:0]           pci_command_reg
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    // a pci master asking for configuration space
    sequence s_pci_cfg;
        req_valid && req_init == SAR_INIT_PCI && req_tgt == SAR_TGT_PCI_CFG;
    endsequence
    // a pci-space request from anyone but a pci master
    sequence s_win_req;
        req_valid && req_init != SAR_INIT_PCI && req_tgt inside {SAR_TGT_PCI_MEM, SAR_TGT_PCI_IO, SAR_TGT_PCI_CFG};
    endsequence
    property p_answer; req_valid |=> rsp_valid && (rsp_grant_r != rsp_error_r); endproperty
    a_answer: assert property (p_answer) else $error("answer missing or ambiguous");
    property p_quiet; !req_valid |=> !rsp_valid && !rsp_grant_r && !rsp_error_r; endproperty
    a_quiet: assert property (p_quiet) else $error("answer without request");
    property p_refuse; rsp_error_r |-> rsp_path_r == SAR_PATH_NONE && !rsp_pci_master_r; endproperty
    a_refuse: assert property (p_refuse) else $error("refused access still routed");
    property p_foreign; s_pci_cfg ##0 !req_self_cfg |=> rsp_error_r; endproperty
    a_foreign: assert property (p_foreign) else $error("foreign config forwarded");
    property p_self; s_pci_cfg ##0 req_self_cfg |=> rsp_grant_r && rsp_path_r == SAR_PATH_SELFCFG; endproperty
    a_self: assert property (p_self) else $error("own config refused");
    property p_local; req_valid && req_init == SAR_INIT_LOCAL |=> rsp_error_r || rsp_path_r == SAR_PATH_DMA; endproperty
    a_local: assert property (p_local) else $error("local master not via dma");
    property p_pci_io; req_valid && req_init == SAR_INIT_PCI && req_tgt == SAR_TGT_PCI_IO |=> rsp_error_r; endproperty
    a_pci_io: assert property (p_pci_io) else $error("pci io granted to pci master");
    property p_window; s_win_req ##1 1'b1 |-> rsp_grant_r == rsp_pci_master_r && (rsp_error_r || $past(win_hit)); endproperty
    a_window: assert property (p_window) else $error("pci space bypassed window");
    property p_base_rst; $rose(resetn) |-> intreg_base_r == SAR_INTREG_BASE_RST; endproperty
    a_base_rst: assert property (p_base_rst) else $error("register base wrong after reset");
    property p_cmd_rst;
        $rose(resetn) |=> pci_command_reg == ($past(central_resource_strap) ? SAR_PCI_COMMAND_REG_RST_ASRT : SAR_PCI_COMMAND_REG_RST_NEG);
    endproperty
    a_cmd_rst: assert property (p_cmd_rst) else $error("command reset value wrong");
    property p_cpu_wr;
        req_valid && req_init == SAR_INIT_CPU && req_cpu_write && !req_cpu_pipelined |=> rsp_error_r;
    endproperty
    a_cpu_wr: assert property (p_cpu_wr) else $error("non-pipelined cpu write granted");
    property p_no_loop;
        req_valid && req_init == SAR_INIT_LOCAL && req_tgt == SAR_TGT_LOCAL |=> rsp_error_r;
    endproperty
    a_no_loop: assert property (p_no_loop) else $error("local master routed back to local bus");
endmodule
bind sar_router sar_router_monitor i_mon (.clk, .resetn, .req_valid, .req_init, .req_tgt, .req_self_cfg,
    .req_cpu_write, .req_cpu_pipelined, .win_hit,
    .central_resource_strap, .rsp_valid, .rsp_grant_r, .rsp_error_r, .rsp_path_r, .rsp_pci_master_r,
    .intreg_base_r, .pci_command_reg);
`default_nettype wire

// File: bench/sar_initiator_model.sv
// initiator model: cpu, dma, pci and local-bus masters toward the router.
// assumes the bench calls send or idle once per clock.
`timescale 1ns/100ps
`default_nettype none
module sar_initiator_model
    import sar_pkg::*;
(
    input  wire logic                  clk,
    output var  logic                  req_valid,
    output sar_pkg::sar_init_type      req_init,
    output sar_pkg::sar_tgt_type       req_tgt,
    output logic [2:0]                 req_ext_idx,
    output logic                       req_self_cfg,
    output logic                       req_idsel,
    output logic                       req_cpu_write,
    output logic                       req_cpu_pipelined,
    output logic                       win_hit
);
    logic [12:0] fld_r; // packed request fields
    initial
    begin
        req_valid = 1'b0;
        fld_r     = 13'h0000;
    end
    assign req_init          = sar_init_type'(fld_r[12:11]);
    assign req_tgt           = sar_tgt_type'(fld_r[10:8]);
    assign req_ext_idx       = fld_r[7:5];
    assign req_self_cfg      = fld_r[4];
    assign req_idsel         = fld_r[3];
    assign req_cpu_write     = fld_r[2];
    assign req_cpu_pipelined = fld_r[1];
    assign win_hit           = fld_r[0];
    task automatic send(input logic [12:0] f);
        @(posedge clk);
        req_valid <= 1'b1;
        fld_r     <= f;
    endtask
    // released fields flip, so a stale value never looks live
    task automatic idle();
        @(posedge clk);
        req_valid <= 1'b0;
        fld_r     <= ~fld_r;
    endtask
endmodule
`default_nettype wire

// File: bench/system_access_router_bench.sv
// self-checking bench for sar_router with the initiator model.
// assumes answers one cycle after each request.
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin errors++; $display("[FAIL] %0t got %h want %h", $time, a, b); end end
module system_access_router_bench;
    import sar_pkg::*;
    logic                 clk, resetn, strap, cmd_wr_en, base_wr_en, req_valid, req_self_cfg, req_idsel;
    logic                 req_cpu_write, req_cpu_pipelined, win_hit, rsp_valid, rsp_grant_r, rsp_error_r;
    logic                 rsp_pci_master_r, rsp_local_bus_r;
    logic [2:0]           req_ext_idx;
    logic [6:0]           ext_rep, ext_loc, ext_device_select_r;
    logic [15:0]          cmd_wr_data, pci_command_reg;
    logic [35:0]          base_wr_data, intreg_base_r;
    logic [14:0]          exp_q;
    logic [12:0]          f;
    sar_init_type         req_init;
    sar_tgt_type          req_tgt;
    sar_path_type         rsp_path_r;
    int                   errors, tests_run;
    // hand-picked awkward requests
    logic [12:0] corner [10] = '{13'h140b, 13'h141b, 13'h1303, 13'h1f02, 13'h0204, 13'h1dc2, 13'h0de2,
                                 13'h0202, 13'h0a02, 13'h05c2};
    sar_initiator_model i_init (.clk, .req_valid, .req_init, .req_tgt, .req_ext_idx, .req_self_cfg, .req_idsel,
        .req_cpu_write, .req_cpu_pipelined, .win_hit);
    sar_router i_dut (.clk, .resetn, .req_valid, .req_init, .req_tgt, .req_ext_idx, .req_self_cfg, .req_idsel,
        .req_cpu_write, .req_cpu_pipelined, .win_hit, .ext_repurposed(ext_rep), .ext_on_local(ext_loc),
        .central_resource_strap(strap), .cmd_wr_en, .cmd_wr_data, .base_wr_en, .base_wr_data, .rsp_valid,
        .rsp_grant_r, .rsp_error_r, .rsp_path_r, .rsp_pci_master_r, .rsp_local_bus_r, .ext_device_select_r,
        .intreg_base_r, .pci_command_reg);
    // expected answer: {valid, grant, error, path, pci master, local bus, select}
    function automatic logic [14:0] expect_rsp(input logic [12:0] q);
        logic g, m, lb;
        logic [2:0] p, ix;
        logic [6:0] s;
        ix = q[7:5];
        {g, m, lb, p, s} = {3'b000, 3'(SAR_PATH_DIRECT), 7'h00};
        case (q[10:8])
            3'h2, 3'h3, 3'h4:
                if (q[12:11] == 2'h2)
                    {g, p} = {q[10:8] == 3'h4 && q[4], 3'(SAR_PATH_SELFCFG)};
                else
                    {g, m, p} = {q[0], q[0], 3'(SAR_PATH_PCIWIN)};
            3'h5:
                if (ix < 3'h7 && !ext_rep[ix] && !(q[12:11] == 2'h3 && ext_loc[ix]))
                    {g, lb, s} = {1'b1, ext_loc[ix], 7'h01 << ix};
            // local-bus targets only for cpu and dma, whose codes have a clear top bit
            3'h7: g = !q[12];
            default: g = 1'b1;
        endcase
        if (q[12:11] == 2'h0 && q[2] && !q[1])
            g = 1'b0;
        if (q[12:11] == 2'h3)
            p = 3'(SAR_PATH_DMA);
        if (!g)
            {m, lb, p, s} = 12'h000;
        return {1'b1, g, !g, p, m, lb, s};
    endfunction
    task automatic report_and_stop();
        $display("checks %0d errors %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // one cycle: optional request, then check the answer of the previous one
    task automatic step(input logic v, input logic [12:0] q);
        if (v)
            i_init.send(q);
        else
            i_init.idle();
        #1;
        `CHK({rsp_valid, rsp_grant_r, rsp_error_r, rsp_path_r, rsp_pci_master_r, rsp_local_bus_r, ext_device_select_r}, exp_q)
        exp_q = v ? expect_rsp(q) : 15'h0000;
    endtask
    task automatic do_reset(input logic s);
        resetn <= 1'b0;
        strap  <= s;
        step(1'b0, 13'h0000);
        step(1'b0, 13'h0000);
        `CHK(intreg_base_r, SAR_INTREG_BASE_RST)
        resetn <= 1'b1;
        step(1'b0, 13'h0000);
        `CHK(pci_command_reg, s ? SAR_PCI_COMMAND_REG_RST_ASRT : SAR_PCI_COMMAND_REG_RST_NEG)
        step(1'b0, 13'h0000);
    endtask
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // hang guard
    initial
    begin
        #80000;
        errors++;
        $display("[FAIL] %0t run limit reached", $time);
        report_and_stop();
    end
    initial
    begin
        {resetn, strap, cmd_wr_en, base_wr_en, ext_rep, ext_loc, cmd_wr_data, base_wr_data} = '0;
        {errors, tests_run, exp_q} = '0;
        void'($urandom(32'hf558be02));
        do_reset(1'b0);
        // register writes land on the next edge
        {cmd_wr_en, base_wr_en, cmd_wr_data, base_wr_data} <= {2'b11, 16'($urandom), 36'({$urandom, $urandom})};
        step(1'b0, 13'h0000);
        `CHK(pci_command_reg, cmd_wr_data)
        `CHK(intreg_base_r, base_wr_data)
        {cmd_wr_en, base_wr_en} <= 2'b00;
        for (int b = 0; b < 12; b++)
        begin
            // let the last answer be checked before reset wipes it
            if (b == 6)
            begin
                step(1'b0, 13'h0000);
                do_reset(1'b1);
            end
            {ext_rep, ext_loc} <= (b == 0) ? 14'h0040 : 14'($urandom);
            step(1'b0, 13'h0000);
            step(1'b0, 13'h0000);
            for (int i = 0; i < 50; i++)
            begin
                f = (b == 0 && i < 10) ? corner[i] : 13'($urandom);
                if (f[12:11] != 2'h0)
                    f[2] = 1'b0;
                f[1] = (b == 0 && i < 10) ? f[1] : ($urandom_range(7) != 0);
                step(1'b1, f);
            end
        end
        step(1'b0, 13'h0000);
        report_and_stop();
    end
endmodule
`undef CHK
`default_nettype wire
